// >>> dbm_ctrl.sv
/*
 * Dual-core boot and mode controller: captures the mode select bit after reset,
 * drives the mode-dependent map and checker controls, in parallel mode holds the secondary
 * core in reset until the key sequence, and raises the run-mode-change NMI to both cores.
 * Assumes the user configuration word is valid while cfg_valid is high and that
 * core_rst_n is an ordinary power-on reset seen through aresetn.
 */
// The implementer's own choice: the AXI4-Lite interface to the registers.
// Operation
// - At power-on, select parallel mode if the mode select bit is zero.
// - The mode select bit is bit 9 of the user configuration word.
// - Parallel mode lets cores run independently and disables redundancy checkers.
// - Lock-step mode maps SRAM as one 128 KB region at 0x4000_0000.
// - Parallel mode splits SRAM into 64 KB at 0x4000_0000 and 0x5000_0000.
// - Replicated peripherals share a map in lock-step, second set moves in parallel.
// - Non-replicated peripherals keep their addresses in every mode.
// - In parallel mode the primary runs while the secondary stays in reset.
// - Boot vector bits 0 to 29 form the secondary reset vector.
// - Bit 30 picks variable-length encoding when one; bit 31 is ignored.
// - Release needs two consecutive key writes, 0x5AF0 then 0xA50F, in order.
// - After the second key the secondary leaves reset at the programmed vector.
// - Moving from initial run mode to first application mode raises NMI to both.
`timescale 1ns/1ns
`default_nettype none
module dbm_ctrl (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// User configuration word from the shadow flash
	input  wire logic [31:0] user_cfg_word,
	input  wire logic        cfg_valid,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core controls
	output logic             secondary_rst_n,
	output logic [31:0]      secondary_reset_vector,
	output logic             secondary_variable_length_encoding,
	output logic             redundancy_checker_en,
	output logic             nmi_primary,
	output logic             nmi_secondary,
	// Address map controls
	output logic             decoupled_parallel_mode,
	output logic             sram_split,
	output logic [31:0]      sram_size_primary,
	output logic [31:0]      sram_base_secondary,
	output logic             replicated_set_split,
	// Interrupt
	output logic             irq
);
	dbm_key_if key ();

	dbm_pkg::dbm_state_t state_r;
	dbm_pkg::dbm_run_t   run_mode_r;
	logic                parallel_r;
	logic [31:0]         boot_vector_r;
	logic [2:0]          irq_status_r;
	logic [2:0]          irq_mask_r;
	logic                aw_held_r;
	logic                w_held_r;
	logic [7:0]          aw_addr_r;
	logic [31:0]         w_data_r;
	logic [3:0]          w_strb_r;
	logic                wr_go;
	logic                first_application_run_mode_req;
	logic                wr_ok;
	logic                rd_ok;
	logic [31:0]         rd_data;
	logic [2:0]          irq_event;

	dbm_key_check u_key (
		.aclk    (aclk),
		.aresetn (aresetn),
		.key     (key)
	);

	// ------------------------------------------------------------
	// Mode capture
	// ------------------------------------------------------------
	// The mode is latched once after reset and frozen; changing it takes a new
	// power-on reset, as the map outputs must never move under running code.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= dbm_pkg::ST_CFG_READ;
			parallel_r <= 1'b0;
		end else begin
			unique case (state_r)
				dbm_pkg::ST_CFG_READ: begin
					if (cfg_valid) begin
						parallel_r <= !user_cfg_word[dbm_pkg::MODE_SELECT_BIT];
						state_r    <= user_cfg_word[dbm_pkg::MODE_SELECT_BIT]
							? dbm_pkg::ST_BOTH_RUN : dbm_pkg::ST_PRIMARY_ONLY;
					end
				end
				dbm_pkg::ST_PRIMARY_ONLY: begin
					if (key.release_stb) begin
						state_r <= dbm_pkg::ST_BOTH_RUN;
					end
				end
				dbm_pkg::ST_BOTH_RUN: begin
					state_r <= dbm_pkg::ST_BOTH_RUN;
				end
			endcase
		end
	end

	assign key.enable = (state_r == dbm_pkg::ST_PRIMARY_ONLY) && parallel_r;

	// ------------------------------------------------------------
	// Core and map outputs
	// ------------------------------------------------------------
	// Before the mode is known the secondary core stays in reset and checkers run, the safe side.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			secondary_rst_n         <= 1'b0;
			redundancy_checker_en   <= 1'b1;
			decoupled_parallel_mode <= 1'b0;
			sram_split              <= 1'b0;
			sram_size_primary       <= dbm_pkg::SRAM_SIZE_LS;
			sram_base_secondary     <= dbm_pkg::SRAM_BASE_A;
			replicated_set_split    <= 1'b0;
		end else begin
			secondary_rst_n         <= (state_r == dbm_pkg::ST_BOTH_RUN);
			redundancy_checker_en   <= !parallel_r;
			decoupled_parallel_mode <= parallel_r;
			sram_split              <= parallel_r;
			sram_size_primary       <= parallel_r ? dbm_pkg::SRAM_SIZE_DP : dbm_pkg::SRAM_SIZE_LS;
			sram_base_secondary     <= parallel_r ? dbm_pkg::SRAM_BASE_B : dbm_pkg::SRAM_BASE_A;
			replicated_set_split    <= parallel_r;
		end
	end

	// Bits 0 to 29 counted from the top are the word address; bit 31 is bit 0 here and never reaches the core.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			secondary_reset_vector             <= 32'h0000_0000;
			secondary_variable_length_encoding <= 1'b0;
		end else begin
			secondary_reset_vector             <= {boot_vector_r[dbm_pkg::VEC_ADDR_MSB:dbm_pkg::VEC_ADDR_LSB], 2'h0};
			secondary_variable_length_encoding <= boot_vector_r[dbm_pkg::VEC_ENCODING_BIT];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			aw_addr_r     <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r     <= 1'b0;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (aw_addr_r)
			dbm_pkg::OFF_MODE_STATUS,
			dbm_pkg::OFF_IRQ_STATUS,
			dbm_pkg::OFF_IRQ_MASK,
			dbm_pkg::OFF_RUN_MODE,
			dbm_pkg::OFF_BOOT_VECTOR,
			dbm_pkg::OFF_RELEASE_KEY: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_vector_r <= dbm_pkg::BOOT_VECTOR_RST;
		end else if (wr_go && aw_addr_r == dbm_pkg::OFF_BOOT_VECTOR) begin
			for (int i = 0; i < 4; i++) begin
				if (w_strb_r[i]) begin
					boot_vector_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
				end
			end
		end
	end

	// The key register is write-only; a key write needs both low byte lanes.
	assign key.wr_stb  = wr_go && (aw_addr_r == dbm_pkg::OFF_RELEASE_KEY) && (w_strb_r[1:0] == 2'h3);
	assign key.wr_data = w_data_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_r <= dbm_pkg::IRQ_MASK_RST;
		end else if (wr_go && aw_addr_r == dbm_pkg::OFF_IRQ_MASK && w_strb_r[0]) begin
			irq_mask_r <= w_data_r[dbm_pkg::IRQ_BITS-1:0];
		end
	end

	// Writing one to bit 0 of the run mode register requests the move to the
	// first application run mode; the move happens once only.
	assign first_application_run_mode_req = wr_go && (aw_addr_r == dbm_pkg::OFF_RUN_MODE) && w_strb_r[0] && w_data_r[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_mode_r <= dbm_pkg::RM_INITIAL;
		end else if (first_application_run_mode_req && run_mode_r == dbm_pkg::RM_INITIAL) begin
			run_mode_r <= dbm_pkg::RM_APP0;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	always_comb begin
		irq_event = 3'h0;
		irq_event[dbm_pkg::IRQ_RELEASE_BIT] = key.release_stb;
		irq_event[dbm_pkg::IRQ_FIRST_APPLICATION_RUN_MODE_BIT]    = first_application_run_mode_req && (run_mode_r == dbm_pkg::RM_INITIAL);
		irq_event[dbm_pkg::IRQ_KEYERR_BIT]  = key.error_stb;
	end

	// A new event beats a write-one-to-clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= 3'h0;
		end else begin
			for (int i = 0; i < dbm_pkg::IRQ_BITS; i++) begin
				if (irq_event[i]) begin
					irq_status_r[i] <= 1'b1;
				end else if (wr_go && aw_addr_r == dbm_pkg::OFF_IRQ_STATUS && w_strb_r[0] && w_data_r[i]) begin
					irq_status_r[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_r & irq_mask_r);
		end
	end

	// The NMI is one level to both cores, held until a core clears the shared bit through the status
	// register; the run-mode bit doubles as the NMI source so neither edge can be lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_primary   <= 1'b0;
			nmi_secondary <= 1'b0;
		end else begin
			nmi_primary   <= irq_status_r[dbm_pkg::IRQ_FIRST_APPLICATION_RUN_MODE_BIT];
			nmi_secondary <= irq_status_r[dbm_pkg::IRQ_FIRST_APPLICATION_RUN_MODE_BIT];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (s_axi_araddr)
			dbm_pkg::OFF_MODE_STATUS: rd_data = {27'h0, run_mode_r == dbm_pkg::RM_APP0,
				state_r == dbm_pkg::ST_BOTH_RUN, state_r != dbm_pkg::ST_CFG_READ, 1'b0, parallel_r};
			dbm_pkg::OFF_IRQ_STATUS:  rd_data = {29'h0, irq_status_r};
			dbm_pkg::OFF_IRQ_MASK:    rd_data = {29'h0, irq_mask_r};
			dbm_pkg::OFF_RUN_MODE:    rd_data = {31'h0, run_mode_r == dbm_pkg::RM_APP0};
			dbm_pkg::OFF_BOOT_VECTOR: rd_data = boot_vector_r;
			dbm_pkg::OFF_RELEASE_KEY: rd_data = 32'h0000_0000;
			default:                  rd_ok   = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : dbm_ctrl
`default_nettype wire

// >>> dbm_pkg.sv
/*
 * Package for the dual-core boot and mode controller: register offsets, key values,
 * field positions, address map constants and reset values.
 * Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
 */
package dbm_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_MODE_STATUS = 8'h00;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h08;
	localparam logic [7:0] OFF_RUN_MODE    = 8'h0c;
	localparam logic [7:0] OFF_BOOT_VECTOR = 8'h18;
	localparam logic [7:0] OFF_RELEASE_KEY = 8'h1c;

	// ------------------------------------------------------------
	// Release key sequence
	// ------------------------------------------------------------
	localparam logic [15:0] KEY_FIRST  = 16'h5af0;
	localparam logic [15:0] KEY_SECOND = 16'ha50f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	// Register bits are numbered from the top, so bit 9 of the configuration word is bit 22 here.
	localparam int MODE_SELECT_BIT  = 22;
	localparam int VEC_ENCODING_BIT = 1;
	localparam int VEC_ADDR_MSB     = 31;
	localparam int VEC_ADDR_LSB     = 2;
	localparam int IRQ_RELEASE_BIT  = 0;
	localparam int IRQ_FIRST_APPLICATION_RUN_MODE_BIT     = 1;
	localparam int IRQ_KEYERR_BIT   = 2;
	localparam int IRQ_BITS         = 3;

	// ------------------------------------------------------------
	// Reset values and address map
	// ------------------------------------------------------------
	localparam logic [31:0] BOOT_VECTOR_RST = 32'h0000_0000;
	localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;
	localparam logic [31:0] USER_CFG_ADDR   = 32'h00f0_3e10;
	localparam logic [31:0] SRAM_BASE_A     = 32'h4000_0000;
	localparam logic [31:0] SRAM_BASE_B     = 32'h5000_0000;
	localparam logic [31:0] SRAM_SIZE_LS    = 32'h0002_0000;
	localparam logic [31:0] SRAM_SIZE_DP    = 32'h0001_0000;

	// Boot progress of the controller.
	typedef enum logic [1:0] {
		ST_CFG_READ,
		ST_PRIMARY_ONLY,
		ST_BOTH_RUN
	} dbm_state_t;

	// Chip run mode as software sees it.
	typedef enum logic [1:0] {
		RM_INITIAL,
		RM_APP0
	} dbm_run_t;

endpackage : dbm_pkg

// >>> dbm_key_if.sv
/*
 * Interface carrying key writes from the register slave to the key checker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface dbm_key_if;
	logic        wr_stb;
	logic [31:0] wr_data;
	logic        enable;
	logic        release_stb;
	logic        error_stb;

	modport ctrl (output wr_stb, output wr_data, output enable, input release_stb, input error_stb);
	modport chk  (input wr_stb, input wr_data, input enable, output release_stb, output error_stb);
endinterface : dbm_key_if
`default_nettype wire

// >>> dbm_key_check.sv
/*
 * Two-word release key checker. A pulse on release_stb follows the accepted
 * second key by one cycle.
 * Assumes writes arrive as one-cycle strobes on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module dbm_key_check (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Key writes
	dbm_key_if.chk    key
);
	logic armed_r;

	// ------------------------------------------------------------
	// Sequence tracking
	// ------------------------------------------------------------
	// Any other value after the first key drops the partial sequence, so a stray
	// write can never complete a release by chance.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_r <= 1'b0;
		end else if (!key.enable) begin
			armed_r <= 1'b0;
		end else if (key.wr_stb) begin
			armed_r <= (key.wr_data[15:0] == dbm_pkg::KEY_FIRST) && !armed_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key.release_stb <= 1'b0;
			key.error_stb   <= 1'b0;
		end else begin
			key.release_stb <= key.enable && key.wr_stb && armed_r
				&& (key.wr_data[15:0] == dbm_pkg::KEY_SECOND);
			key.error_stb   <= key.enable && key.wr_stb && armed_r
				&& (key.wr_data[15:0] != dbm_pkg::KEY_SECOND);
		end
	end
endmodule : dbm_key_check
`default_nettype wire

// >>> dbm_ctrl_checker.sv
/*
 * Concurrent checks on the boot and mode controller, seen only from its ports.
 * Assumes one clock, a synchronous active-low reset and a bench holding bready high.
 */
`timescale 1ns/1ns
`default_nettype none
module dbm_ctrl_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// Core and map controls
	input wire logic        secondary_rst_n,
	input wire logic [31:0] secondary_reset_vector,
	input wire logic        secondary_variable_length_encoding,
	input wire logic        redundancy_checker_en,
	input wire logic        nmi_primary,
	input wire logic        nmi_secondary,
	input wire logic        decoupled_parallel_mode,
	input wire logic        sram_split,
	input wire logic [31:0] sram_size_primary,
	input wire logic [31:0] sram_base_secondary,
	input wire logic        replicated_set_split
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [7:0]  aw_r;
	logic [31:0] wd_r;
	logic        arm_r;
	logic [2:0]  k2_age_r;
	logic        wr_done;
	logic        key_wr;
	logic        key2_ok;

	// A write retires at its response handshake; address and data were captured earlier.
	assign wr_done = s_axi_bvalid && s_axi_bready;
	assign key_wr  = wr_done && aw_r == 8'h1c;
	assign key2_ok = key_wr && arm_r && wd_r[15:0] == 16'ha50f && decoupled_parallel_mode;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r     <= 8'h00;
			wd_r     <= 32'h0;
			arm_r    <= 1'b0;
			k2_age_r <= 3'h7;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
			if (key_wr) arm_r <= (wd_r[15:0] == 16'h5af0) && !arm_r;
			k2_age_r <= key2_ok ? 3'h0 : (k2_age_r == 3'h7) ? k2_age_r : k2_age_r + 3'h1;
		end
	end

	sequence s_release;
		##[1:4] secondary_rst_n;
	endsequence
	sequence s_wr_resp;
		##[1:2] s_axi_bvalid;
	endsequence

	a_split_map: assert property (decoupled_parallel_mode [*2] |-> sram_split && replicated_set_split
		&& !redundancy_checker_en && sram_size_primary == 32'h0001_0000 && sram_base_secondary == 32'h5000_0000)
		else $error("parallel map outputs wrong");
	a_lock_map: assert property ((!decoupled_parallel_mode) [*2] |-> !sram_split && !replicated_set_split
		&& redundancy_checker_en && sram_size_primary == 32'h0002_0000 && sram_base_secondary == 32'h4000_0000)
		else $error("lock-step map outputs wrong");
	a_key_release: assert property (key2_ok |-> s_release)
		else $error("secondary not released after key pair");
	a_release_cause: assert property ($rose(secondary_rst_n) && decoupled_parallel_mode |-> k2_age_r < 3'h5)
		else $error("secondary released without key pair");
	a_no_rehold: assert property (!$fell(secondary_rst_n))
		else $error("secondary put back into reset");
	a_vector_out: assert property (wr_done && aw_r == 8'h18 |-> ##[1:2] (secondary_reset_vector == {wd_r[31:2], 2'b00}
		&& secondary_variable_length_encoding == wd_r[1])) else $error("boot vector outputs wrong");
	a_nmi_both: assert property (nmi_primary == nmi_secondary)
		else $error("nmi outputs differ");
	a_nmi_run: assert property (wr_done && aw_r == 8'h0c && wd_r[0] && !nmi_primary |-> ##[0:2] nmi_primary)
		else $error("no nmi after run mode change");
	a_bad_addr: assert property (wr_done && !(aw_r inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c})
		|-> s_axi_bresp == 2'b10) else $error("unmapped write not refused");
	a_wr_resp: assert property (s_axi_awready && s_axi_wready |-> s_wr_resp)
		else $error("write response late");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule : dbm_ctrl_checker

bind dbm_ctrl dbm_ctrl_checker dbm_ctrl_checker_i (.*);
`default_nettype wire

// >>> dbm_sec_core.sv
/*
 * Behavioural secondary core: latches its start address when let out of reset,
 * runs a short init, then asks for the run mode change and serves its NMI.
 * Assumes the controller's clock; the bench performs the bus writes it asks for.
 */
`timescale 1ns/1ns
`default_nettype none
module dbm_sec_core #(
	parameter int INIT_CYC = 24
) (
	// Clock
	input  wire logic        aclk,
	// Controls from the controller
	input  wire logic        secondary_rst_n,
	input  wire logic [31:0] secondary_reset_vector,
	input  wire logic        secondary_variable_length_encoding,
	input  wire logic        nmi_secondary,
	// Observed behaviour
	output logic [31:0]      fetch_addr,
	output logic             fetch_vle,
	output logic             run_req,
	output logic             nmi_done
);
	int   init_r;
	logic up_r;

	always_ff @(posedge aclk) begin
		if (!secondary_rst_n) begin
			init_r   <= 0;
			up_r     <= 1'b0;
			run_req  <= 1'b0;
			nmi_done <= 1'b0;
		end else begin
			up_r <= 1'b1;
			if (!up_r) begin
				fetch_addr <= secondary_reset_vector;
				fetch_vle  <= secondary_variable_length_encoding;
			end
			// A slow init keeps the run mode request well clear of the release.
			if (init_r < INIT_CYC) init_r <= init_r + 1;
			else run_req <= 1'b1;
			if (run_req && nmi_secondary) nmi_done <= 1'b1;
		end
	end
endmodule : dbm_sec_core
`default_nettype wire

// >>> dual_core_boot_mode_control_tb_top.sv
/*
 * Self-checking bench for the boot and mode controller with a secondary core model.
 * Assumes a 250 MHz clock and an AXI4-Lite master that holds requests until taken.
 */
`timescale 1ns/1ns
`default_nettype none
module dual_core_boot_mode_control_tb_top;
	logic        aclk, aresetn, cfg_valid, irq, fetch_vle, run_req, nmi_done;
	logic [31:0] user_cfg_word, s_axi_wdata, s_axi_rdata, secondary_reset_vector;
	logic [31:0] sram_size_primary, sram_base_secondary, fetch_addr, rd_d;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, secondary_rst_n;
	logic        secondary_variable_length_encoding, redundancy_checker_en, nmi_primary, nmi_secondary;
	logic        decoupled_parallel_mode, sram_split, replicated_set_split;
	int          error_cnt, check_count, n;

	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} dbm_row_t;
	localparam dbm_row_t rows [7] = '{
		'{1'b1, 8'h18, 32'hc000_1237, 32'h0, 2'h0},
		'{1'b0, 8'h18, 32'h0, 32'hc000_1237, 2'h0},
		'{1'b1, 8'h08, 32'h0000_0007, 32'h0, 2'h0},
		'{1'b0, 8'h08, 32'h0, 32'h0000_0007, 2'h0},
		'{1'b0, 8'h1c, 32'h0, 32'h0, 2'h0},
		'{1'b1, 8'h20, 32'h1, 32'h0, 2'h2},
		'{1'b0, 8'h00, 32'h0, 32'h0000_0005, 2'h0}};

	dbm_ctrl dbm_ctrl_i (.*);
	dbm_sec_core dbm_sec_core_i (.*);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(aw && w) && n < 50) begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) aw = 1'b1;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) w = 1'b1;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) error_cnt++;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		n = 0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 50);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		rd_d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) error_cnt++;
	endtask : rd

	// Waits for the released core, its run request, or its NMI service.
	task automatic wt(input int k);
		n = 0;
		while ((k == 0 ? secondary_rst_n : k == 1 ? run_req : nmi_done) !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 200) error_cnt++;
	endtask : wt

	task automatic rst(input logic [31:0] w);
		@(posedge aclk);
		aresetn       <= 1'b0;
		cfg_valid     <= 1'b0;
		user_cfg_word <= w;
		repeat (12) @(posedge aclk);
		chk({27'h0, redundancy_checker_en, secondary_rst_n, nmi_primary, irq, decoupled_parallel_mode}, 32'h10);
		chk(sram_size_primary | sram_base_secondary, 32'h4002_0000);
		aresetn <= 1'b1;
		@(posedge aclk);
		cfg_valid <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask : rst

	initial begin
		{aresetn, cfg_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
		{user_cfg_word, s_axi_wdata, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 84'h0;
		rst(32'hffbf_ffff);
		chk({26'h0, decoupled_parallel_mode, sram_split, replicated_set_split, redundancy_checker_en,
			secondary_rst_n, irq}, 32'h38);
		chk(sram_size_primary, 32'h0001_0000);
		chk(sram_base_secondary, 32'h5000_0000);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rd(rows[i].a);
			if (!rows[i].w) chk(rd_d, rows[i].x);
			chk({30'h0, rs}, {30'h0, rows[i].r});
		end
		chk(secondary_reset_vector, 32'hc000_1234);
		chk({31'h0, secondary_variable_length_encoding}, 32'h1);
		// A broken pair must leave the core held and flag an error interrupt.
		wr(8'h1c, 32'h5af0);
		wr(8'h1c, 32'h1234);
		rd(8'h04);
		chk(rd_d, 32'h4);
		chk({30'h0, secondary_rst_n, irq}, 32'h1);
		wr(8'h04, 32'h4);
		rd(8'h04);
		chk(rd_d, 32'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(8'h1c, 32'ha50f);
		repeat (6) @(posedge aclk);
		chk({31'h0, secondary_rst_n}, 32'h0);
		wr(8'h04, 32'h7);
		wr(8'h18, 32'h0000_0400);
		wr(8'h1c, 32'h5af0);
		wr(8'h1c, 32'ha50f);
		wt(0);
		chk({31'h0, secondary_rst_n}, 32'h1);
		repeat (2) @(posedge aclk);
		chk(fetch_addr, 32'h0000_0400);
		chk({31'h0, fetch_vle}, 32'h0);
		rd(8'h04);
		chk(rd_d, 32'h1);
		rd(8'h00);
		chk(rd_d, 32'h0000_000d);
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h0);
		wt(1);
		wr(8'h0c, 32'h1);
		repeat (2) @(posedge aclk);
		chk({29'h0, nmi_primary, nmi_secondary, irq}, 32'h6);
		rd(8'h0c);
		chk(rd_d, 32'h1);
		wr(8'h08, 32'h2);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wt(2);
		wr(8'h04, 32'h2);
		repeat (2) @(posedge aclk);
		chk({29'h0, nmi_primary, nmi_secondary, irq}, 32'h0);
		// Second reset in mid-run, now with the lock-step selection.
		rst(32'hffff_ffff);
		chk({26'h0, decoupled_parallel_mode, sram_split, replicated_set_split, redundancy_checker_en,
			secondary_rst_n, irq}, 32'h06);
		chk(sram_size_primary | sram_base_secondary, 32'h4002_0000);
		wr(8'h1c, 32'h5af0);
		wr(8'h1c, 32'ha50f);
		rd(8'h04);
		chk(rd_d, 32'h0);
		results();
	end

	initial begin
		#100000;
		error_cnt++;
		results();
	end
endmodule : dual_core_boot_mode_control_tb_top
`default_nettype wire
